// file: core/cds_defs.svh
/*
 * Constants of the serial control and sync block: frame layout, pin slots, timing counts.
 * Assumes the includer runs on sys_clk at 100 MHz.
 */
`ifndef CDS_DEFS_SVH
`define CDS_DEFS_SVH

// ==========================================================================
// Frame layout
`define CDS_FRAME_BITS 5'd16
`define CDS_HDR_BITS 5'd8
`define CDS_RW_BIT 8
`define CDS_ADDR_LSB 9
`define CDS_ADDR_MSB 15
`define CDS_NUM_REGS 8
`define CDS_REG_RESET 8'h00

// ==========================================================================
// Synchronised pin slots
`define CDS_PIN_W 7
`define CDS_PIN_CS_N 0
`define CDS_PIN_SCLK 1
`define CDS_PIN_SDI 2
`define CDS_PIN_SYNC 3
`define CDS_PIN_STRAP0 4

// ==========================================================================
// Timing
`define CDS_CLK_NS 10
`define CDS_SYNC_SETTLE_NS 100
`define CDS_SYNC_CYCLES ((`CDS_SYNC_SETTLE_NS + `CDS_CLK_NS - 1) / `CDS_CLK_NS)

`endif

// file: core/cds_pkg.sv
/*
 * Types of the serial control and sync block.
 * Assumes cds_defs.svh is on the include path.
 */
`include "cds_defs.svh"

package cds_pkg;

  // ========================================================================
  // Serial port states
  typedef enum logic [1:0] {
    CDS_IDLE  = 2'b01,
    CDS_SHIFT = 2'b10
  } cds_state_t;

  // ========================================================================
  // Pin synchroniser state
  typedef struct packed {
    logic [`CDS_PIN_W-1:0] s1;
    logic [`CDS_PIN_W-1:0] s2;
    logic [`CDS_PIN_W-1:0] s3;
    logic [`CDS_PIN_W-1:0] lvl;
    logic [`CDS_PIN_W-1:0] rise;
    logic [`CDS_PIN_W-1:0] fall;
  } cds_sync_st_t;

  // ========================================================================
  // Control block state
  typedef struct packed {
    cds_state_t state;
    logic [4:0] cnt;
    logic [15:0] sh;
    logic [7:0] rd_sr;
    logic sdo;
    logic sdo_oe;
    logic [`CDS_NUM_REGS-1:0][7:0] regs;
    logic commit;
    logic abort;
    logic sync_busy;
    logic [3:0] sync_cnt;
    logic sync_start;
    logic sync_align;
    logic [2:0] lvds;
    logic [2:0] bias;
  } cds_ctrl_st_t;

endpackage : cds_pkg

// file: core/cds_pin_if.sv
/*
 * Carrier between the pin synchroniser and the control block.
 * Assumes both ends run on sys_clk.
 */
`timescale 1ns/10ps
`include "cds_defs.svh"

interface cds_pin_if;
  logic [`CDS_PIN_W-1:0] raw;
  logic [`CDS_PIN_W-1:0] level;
  logic [`CDS_PIN_W-1:0] rise;
  logic [`CDS_PIN_W-1:0] fall;

  modport sync_side (input raw, output level, rise, fall);
  modport user_side (output raw, input level, rise, fall);
endinterface : cds_pin_if

// file: core/cds_pin_sync.sv
/*
 * Three-flop synchroniser with edge detection for every pin of the block.
 * Assumes pins are asynchronous to sys_clk; a change is accepted once stages two and three agree.
 */
`timescale 1ns/10ps
`include "cds_defs.svh"

module cds_pin_sync (
  input wire logic sys_clk, // 100 MHz clock
  input wire logic reset, // Synchronous reset, active high
  cds_pin_if.sync_side pins // Raw pins in, clean levels and edges out
);

  cds_pkg::cds_sync_st_t st_reg;
  cds_pkg::cds_sync_st_t st_next;

  // ========================================================================
  // Per pin filter
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pins.raw;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < `CDS_PIN_W; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.lvl[i] = st_reg.s3[i];
      end
    end
    st_next.rise = st_next.lvl & ~st_reg.lvl;
    st_next.fall = ~st_next.lvl & st_reg.lvl;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_reg <= '0;
      // Stages match the clean level so that no false edge follows reset
      st_reg.s1 <= 7'h01;
      st_reg.s2 <= 7'h01;
      st_reg.s3 <= 7'h01;
      st_reg.lvl <= 7'h01;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pins.level = st_reg.lvl;
  assign pins.rise = st_reg.rise;
  assign pins.fall = st_reg.fall;

endmodule : cds_pin_sync

// file: core/cds_serial_ctrl.sv
/*
 * Serial control port, sync trigger and output mode straps of a three-output clock divider.
 * Assumes pins arrive asynchronously; sclk is far slower than sys_clk (160 ns period in the bench).
 */
// What this block does
// R1: Chip select low opens a new transaction.
// R2: Chip select high after 16 clocks commits.
// R3: Sample data in on each serial clock rise.
// R4: Host shifts write data on data input.
// R5: Read data is driven on data output.
// R6: Sync input rising edge starts output alignment.
// R7: Alignment is retimed internally, pin timing irrelevant.
// R8: Grounded strap selects single-ended CMOS output.
// R9: Strap at supply selects LVDS output.
// R10: LVPECL strap high enables emitter bias.
// R11: Early chip select rise discards the transaction.
`timescale 1ns/10ps
`include "cds_defs.svh"

module cds_serial_ctrl #(
  parameter logic [2:0] PECL_MASK = 3'b001 // Outputs built as LVPECL
) (
  input wire logic sys_clk, // 100 MHz clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic cs_n, // Serial chip select, active low
  input wire logic sclk, // Serial clock
  input wire logic sdi, // Serial data in
  output logic sdo, // Serial data out
  output logic sdo_oe, // Serial data out enable
  input wire logic sync_in, // Sync trigger pin
  input wire logic out0_mode_strap, // Output 0 mode strap
  input wire logic out1_mode_strap, // Output 1 mode strap
  input wire logic out2_mode_strap, // Output 2 mode strap
  output logic [2:0] out_lvds, // 1 LVDS, 0 CMOS per selectable output
  output logic [2:0] out_bias_en, // Emitter bias enable per LVPECL output
  output logic [63:0] cfg_regs, // Stored settings, register n at bits 8n+7:8n
  output logic cfg_commit, // One-cycle pulse after a committed frame, write or read
  output logic frame_abort, // One-cycle pulse after a discarded frame
  output logic sync_start, // One-cycle pulse, sync sequence begins
  output logic sync_align, // One-cycle pulse, outputs realigned
  output logic sync_busy // Level, sync sequence running
);

  localparam logic [3:0] SYNC_CYCLES = 4'(`CDS_SYNC_CYCLES);

  cds_pin_if pins ();
  cds_pkg::cds_ctrl_st_t st_reg;
  cds_pkg::cds_ctrl_st_t st_next;
  logic [2:0] strap_lvl;
  logic [2:0] addr;
  logic addr_ok;

  // ==========================================================================
  // Pin conditioning
  assign pins.raw = {out2_mode_strap, out1_mode_strap, out0_mode_strap, sync_in, sdi, sclk, cs_n};

  cds_pin_sync u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .pins(pins)
  );

  assign strap_lvl = pins.level[`CDS_PIN_STRAP0 +: 3];
  assign addr = st_reg.sh[`CDS_ADDR_LSB +: 3];
  assign addr_ok = (st_reg.sh[`CDS_ADDR_MSB:`CDS_ADDR_LSB+3] == 4'h0);

  // ==========================================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    st_next.commit = 1'b0;
    st_next.abort = 1'b0;
    st_next.sync_start = 1'b0;
    st_next.sync_align = 1'b0;

    unique case (st_reg.state)
      cds_pkg::CDS_IDLE: begin
        st_next.sdo_oe = 1'b0;
        st_next.sdo = 1'b0;
        if (pins.fall[`CDS_PIN_CS_N]) begin // see R1
          st_next.state = cds_pkg::CDS_SHIFT;
          st_next.cnt = 5'h00;
          st_next.sh = 16'h0000;
          st_next.rd_sr = 8'h00;
          st_next.sdo_oe = 1'b1;
        end
      end
      cds_pkg::CDS_SHIFT: begin
        if (pins.rise[`CDS_PIN_CS_N]) begin
          st_next.state = cds_pkg::CDS_IDLE;
          st_next.sdo_oe = 1'b0;
          st_next.sdo = 1'b0;
          if (st_reg.cnt == `CDS_FRAME_BITS) begin // see R2
            st_next.commit = 1'b1;
            if (!st_reg.sh[`CDS_RW_BIT] && addr_ok) begin
              st_next.regs[addr] = st_reg.sh[7:0]; // see R4
            end
          end else begin
            st_next.abort = 1'b1; // see R11
          end
        end else begin
          if (pins.rise[`CDS_PIN_SCLK]) begin
            st_next.sh = {st_reg.sh[14:0], pins.level[`CDS_PIN_SDI]}; // see R3
            if (st_reg.cnt != 5'h1F) begin
              st_next.cnt = st_reg.cnt + 5'h01;
            end
            if (st_reg.cnt == `CDS_HDR_BITS - 5'h01 && pins.level[`CDS_PIN_SDI]) begin
              // Header complete: the bit sampled now is the read flag, the address sits in sh[6:0]
              st_next.rd_sr = (st_reg.sh[6:3] == 4'h0) ? st_reg.regs[st_reg.sh[2:0]] : 8'h00;
            end
          end
          if (pins.fall[`CDS_PIN_SCLK] && st_reg.cnt >= `CDS_HDR_BITS) begin
            st_next.sdo = st_reg.rd_sr[7]; // see R5
            st_next.rd_sr = {st_reg.rd_sr[6:0], 1'b0};
          end
        end
      end
    endcase

    // Sync sequence runs on sys_clk, so pin timing only shifts the start
    if (!st_reg.sync_busy && pins.rise[`CDS_PIN_SYNC]) begin // see R6
      st_next.sync_busy = 1'b1;
      st_next.sync_start = 1'b1;
      st_next.sync_cnt = SYNC_CYCLES;
    end else if (st_reg.sync_busy) begin
      if (st_reg.sync_cnt == 4'h1) begin
        st_next.sync_busy = 1'b0;
        st_next.sync_align = 1'b1; // see R7
      end
      st_next.sync_cnt = st_reg.sync_cnt - 4'h1;
    end

    // Straps: low gives CMOS or bias off, high gives LVDS or bias on
    st_next.lvds = strap_lvl & ~PECL_MASK; // see R8 // see R9
    st_next.bias = strap_lvl & PECL_MASK; // see R10
  end

  // ==========================================================================
  // State register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.state <= cds_pkg::CDS_IDLE;
      st_reg.regs <= {`CDS_NUM_REGS{`CDS_REG_RESET}};
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign sdo = st_reg.sdo;
  assign sdo_oe = st_reg.sdo_oe;
  assign out_lvds = st_reg.lvds;
  assign out_bias_en = st_reg.bias;
  assign cfg_regs = st_reg.regs;
  assign cfg_commit = st_reg.commit;
  assign frame_abort = st_reg.abort;
  assign sync_start = st_reg.sync_start;
  assign sync_align = st_reg.sync_align;
  assign sync_busy = st_reg.sync_busy;

endmodule : cds_serial_ctrl

// file: tb/cds_sva.sv
/* Port checker of cds_serial_ctrl.
   Assumes the bind below and sys_clk as its only clock. */
`timescale 1ns/10ps
module cds_sva #(parameter logic [2:0] PECL_MASK = 3'b001) (
  input wire logic sys_clk, reset, cs_n, sdo, sdo_oe, // Clock, reset, serial pins
  input wire logic out0_mode_strap, out1_mode_strap, out2_mode_strap, // Straps
  input wire logic [2:0] out_lvds, out_bias_en, // Output modes
  input wire logic [63:0] cfg_regs, // Stored settings
  input wire logic cfg_commit, frame_abort, sync_start, sync_align, sync_busy // Pulses and the sync busy level
);
  wire logic [2:0] strap = {out2_mode_strap, out1_mode_strap, out0_mode_strap};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_frame_opens: assert property ($fell(cs_n) |-> ##[1:8] sdo_oe) else $error("frame not opened");
  a_frame_closes: assert property (
    $rose(cs_n) |-> ##[1:8] (cfg_commit || frame_abort)) else $error("frame not closed");
  a_regs_on_commit: assert property ($changed(cfg_regs) |-> cfg_commit) else $error("regs moved");
  a_abort_keeps: assert property (
    frame_abort |-> $stable(cfg_regs) && !cfg_commit) else $error("abort changed regs");
  a_sdo_idle: assert property ((!sdo_oe) [*2] |-> !sdo) else $error("sdo driven idle");
  a_sync_align: assert property (sync_start |-> ##10 sync_align) else $error("align late");
  a_busy_holds: assert property (sync_start |-> sync_busy [*8]) else $error("busy short");
  a_busy_ends: assert property (sync_align |-> !sync_busy && $past(sync_busy)) else $error("busy end");
  a_strap_mode: assert property (
    $stable(strap) [*8] |-> out_lvds == (strap & ~PECL_MASK) && out_bias_en == (strap & PECL_MASK))
    else $error("mode wrong");
  c_commit: cover property (cfg_commit);
  c_abort: cover property (frame_abort);
  c_align: cover property (sync_align);
endmodule : cds_sva

bind cds_serial_ctrl cds_sva #(.PECL_MASK(PECL_MASK)) u_sva (.sys_clk(sys_clk), .reset(reset),
  .cs_n(cs_n), .sdo(sdo), .sdo_oe(sdo_oe), .out0_mode_strap(out0_mode_strap),
  .out1_mode_strap(out1_mode_strap), .out2_mode_strap(out2_mode_strap), .out_lvds(out_lvds),
  .out_bias_en(out_bias_en), .cfg_regs(cfg_regs), .cfg_commit(cfg_commit), .frame_abort(frame_abort),
  .sync_start(sync_start), .sync_align(sync_align), .sync_busy(sync_busy));

// file: tb/cds_host.sv
/* Host model: drives the serial port and the sync pin.
   Assumes sys_clk paces it; sclk period is 16 sys_clk cycles. */
`timescale 1ns/10ps
module cds_host (
  input wire logic sys_clk, // Pacing clock
  input wire logic sdo, // Read data from device
  output logic cs_n = 1'b1, // Chip select
  output logic sclk = 1'b0, // Serial clock, still outside frames
  output logic sdi = 1'b0, // Serial data
  output logic sync_in = 1'b0 // Sync pin
);
  task automatic xfer(input int n, input logic [15:0] w, output logic [7:0] rd);
    @(negedge sys_clk) cs_n = 1'b0;
    rd = '0;
    for (int i = 0; i < n; i++) begin
      sdi = w[(15 - i) & 15];
      repeat (8) @(negedge sys_clk);
      sclk = 1'b1;
      rd = {rd[6:0], sdo};
      repeat (8) @(negedge sys_clk);
      sclk = 1'b0;
    end
    repeat (8) @(negedge sys_clk);
    cs_n = 1'b1;
    sdi = ~sdi;
  endtask : xfer

  task automatic set_sync(input logic v);
    @(negedge sys_clk) sync_in = v;
  endtask : set_sync
endmodule : cds_host

// file: tb/testbench.sv
/* Self-checking bench of cds_serial_ctrl.
   Assumes cds_host and the bound checker are compiled alongside. */
`timescale 1ns/10ps
module testbench;
  localparam logic [2:0] PECL = 3'b101;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] strap = 3'b000;
  wire logic cs_n, sclk, sdi, sync_in, sdo, sdo_oe, cfg_commit, frame_abort, sync_start, sync_align, sync_busy;
  wire logic [2:0] out_lvds, out_bias_en;
  wire logic [63:0] cfg_regs;
  wire logic [2:0] ev = {sync_start, frame_abort, cfg_commit};
  logic [63:0] model = '0;
  logic [7:0] rd;
  int err_count = 0;
  int checked = 0;
  // Frame word, then the byte a read-back should return
  logic [23:0] rows [5] = '{24'h00A5A5, 24'h0E3C3C, 24'h06FFFF, 24'h005A5A, 24'h10C300};

  always #5 sys_clk = ~sys_clk;

  cds_host host (.sys_clk(sys_clk), .sdo(sdo), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sync_in(sync_in));
  cds_serial_ctrl #(.PECL_MASK(PECL)) dut (.sys_clk(sys_clk), .reset(reset), .cs_n(cs_n), .sclk(sclk),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .sync_in(sync_in), .out0_mode_strap(strap[0]),
    .out1_mode_strap(strap[1]), .out2_mode_strap(strap[2]), .out_lvds(out_lvds), .out_bias_en(out_bias_en),
    .cfg_regs(cfg_regs), .cfg_commit(cfg_commit), .frame_abort(frame_abort), .sync_start(sync_start),
    .sync_align(sync_align), .sync_busy(sync_busy));

  task automatic end_of_test;
    $display("Comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wait_ev(input int k);
    int t;
    for (t = 0; t < 40 && ev[k] !== 1'b1; t++) @(negedge sys_clk);
    if (t == 40) begin
      $display("Error event %0d expected 1 seen 0", k);
      err_count++;
      end_of_test();
    end
  endtask : wait_ev

  initial begin
    repeat (12) @(negedge sys_clk);
    reset = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk("reset regs", cfg_regs, 64'h0);
    chk("reset sdo", {sdo_oe, sdo}, 64'h0);
    foreach (rows[i]) begin
      host.xfer(16, rows[i][23:8], rd);
      if (rows[i][23:17] < 7'd8) model[int'(rows[i][23:17]) * 8 +: 8] = rows[i][15:8] == 8'h00 ? 8'h00 : rows[i][15:8];
      wait_ev(0);
      chk("regs", cfg_regs, model);
      host.xfer(16, rows[i][23:8] | 16'h0100, rd);
      wait_ev(0);
      chk("read", rd, rows[i][7:0]);
    end
    for (int k = 12; k <= 17; k += 5) begin
      host.xfer(k, 16'h0077, rd);
      wait_ev(1);
      chk("abort regs", cfg_regs, model);
    end
    for (int s = 0; s < 8; s++) begin
      strap = 3'(s);
      repeat (10) @(negedge sys_clk);
      chk("lvds", out_lvds, 3'(s) & ~PECL);
      chk("bias", out_bias_en, 3'(s) & PECL);
    end
    host.set_sync(1'b1);
    wait_ev(2);
    chk("busy", sync_busy, 64'h1);
    repeat (10) @(negedge sys_clk);
    chk("align", {sync_align, sync_busy}, 64'h2);
    host.set_sync(1'b0);
    reset = 1'b1;
    repeat (3) @(negedge sys_clk);
    reset = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk("rereset regs", cfg_regs, 64'h0);
    end_of_test();
  end
endmodule : testbench
